//--- core/pafs_defines.svh
// register map, reset values, field ranges and function codes of the port a function select
`ifndef PAFS_DEFINES_SVH
`define PAFS_DEFINES_SVH

`define PAFS_OFF_HIGH   4'h0
`define PAFS_OFF_LOW    4'h4
`define PAFS_RST_HIGH   16'h3302
`define PAFS_RST_LOW    16'hff95
`define PAFS_RSV_HIGH   16'h0002
`define PAFS_RSV_LOW    16'haa00

`define PAFS_HI_PIN15   15:14
`define PAFS_HI_PIN14   13:12
`define PAFS_HI_PIN13   11:10
`define PAFS_HI_PIN12   9:8
`define PAFS_HI_PIN11   7:6
`define PAFS_HI_PIN10   5:4
`define PAFS_HI_PIN9    3:2
`define PAFS_HI_PIN8    0
`define PAFS_LO_PIN7    14
`define PAFS_LO_PIN6    12
`define PAFS_LO_PIN5    10
`define PAFS_LO_PIN4    8
`define PAFS_LO_PIN3    7:6
`define PAFS_LO_PIN2    5:4
`define PAFS_LO_PIN1    3:2
`define PAFS_LO_PIN0    1:0

`define PAFS_FN_PORT    2'h0
`define PAFS_FN_ALT1    2'h1
`define PAFS_FN_ALT2    2'h2
`define PAFS_FN_ALT3    2'h3

`endif

//--- core/pafs_pkg.sv
// types shared by the port a function select logic
package pafs_pkg;

  typedef enum logic {
    PAFS_IDLE = 1'b0,
    PAFS_ACK  = 1'b1
  } pafs_state_t;

  typedef struct packed {
    pafs_state_t st;
    logic        wreq;
    logic [15:0] hi;
    logic [15:0] lo;
    logic [31:0] rdata;
    logic [15:0] pin_out;
    logic [15:0] pin_oe;
    logic [15:0] port_in;
    logic [3:0]  irq;
    logic [1:0]  xreq;
    logic [1:0]  tclk;
    logic [3:0]  tcc;
    logic [1:0]  par;
    logic        trg;
    logic        bus_req_in;
    logic        wt;
  } pafs_regs_t;

endpackage

//--- core/pafs_fn_dec.sv
// per-pin function code decoder for the two select registers
`timescale 1ns/100ps
`include "pafs_defines.svh"

module pafs_fn_dec (
  input  wire logic [15:0] hi,
  input  wire logic [15:0] lo,
  output logic      [31:0] fn
);

  // keep a two-bit code unless it is one of the reserved ones
  function automatic logic [1:0] keep(input logic [1:0] code, input logic [1:0] rsv);
    keep = (code == rsv) ? `PAFS_FN_PORT : code;
  endfunction

  // one bit fields map to port or first alternate
  function automatic logic [1:0] one(input logic b);
    one = b ? `PAFS_FN_ALT1 : `PAFS_FN_PORT;
  endfunction

  // fn[2i+1:2i] is the normalised function of pin i
  always_comb begin
    fn[31:30] = keep(hi[`PAFS_HI_PIN15], `PAFS_FN_ALT2);
    fn[29:28] = keep(hi[`PAFS_HI_PIN14], `PAFS_FN_ALT2);
    fn[27:26] = hi[`PAFS_HI_PIN13];
    fn[25:24] = hi[`PAFS_HI_PIN12];
    fn[23:22] = keep(hi[`PAFS_HI_PIN11], `PAFS_FN_ALT3);
    fn[21:20] = keep(hi[`PAFS_HI_PIN10], `PAFS_FN_ALT3);
    fn[19:18] = hi[`PAFS_HI_PIN9];
    fn[17:16] = one(hi[`PAFS_HI_PIN8]);
    fn[15:14] = one(lo[`PAFS_LO_PIN7]);
    fn[13:12] = one(lo[`PAFS_LO_PIN6]);
    fn[11:10] = one(lo[`PAFS_LO_PIN5]);
    fn[9:8]   = one(lo[`PAFS_LO_PIN4]);
    fn[7:6]   = keep(lo[`PAFS_LO_PIN3], `PAFS_FN_ALT3);
    fn[5:4]   = keep(lo[`PAFS_LO_PIN2], `PAFS_FN_ALT3);
    fn[3:2]   = keep(lo[`PAFS_LO_PIN1], `PAFS_FN_ALT3);
    fn[1:0]   = keep(lo[`PAFS_LO_PIN0], `PAFS_FN_ALT3);
  end

endmodule

//--- core/pafs_top.sv
// port a function select: avalon registers and registered pin multiplexer
//
// Local design decisions: the register addresses and the Avalon-MM slave port.
`timescale 1ns/100ps
`include "pafs_defines.svh"

module pafs_top (
  input  wire logic        SYS_CLK,
  input  wire logic        RST_B,
  input  wire logic [3:0]  AVM_ADDRESS,
  input  wire logic        AVM_READ,
  input  wire logic        AVM_WRITE,
  input  wire logic [31:0] AVM_WRITEDATA,
  input  wire logic [3:0]  AVM_BYTEENABLE,
  output logic      [31:0] AVM_READDATA,
  output logic             AVM_WAITREQUEST,
  input  wire logic [15:0] PIN_IN,
  output logic      [15:0] PIN_OUT,
  output logic      [15:0] PIN_OE,
  input  wire logic [15:0] PORT_DOUT,
  input  wire logic [15:0] PORT_DIR,
  output logic      [15:0] PORT_PIN_IN,
  input  wire logic [1:0]  XFER_ACK_OUT,
  input  wire logic        ADDR_HOLD_OUT,
  input  wire logic        IRQ_REQUEST_OUT,
  input  wire logic        BUS_ACK_OUT,
  input  wire logic        READ_STROBE_OUT,
  input  wire logic        UPPER_WRITE_STROBE,
  input  wire logic        LOWER_WRITE_STROBE,
  input  wire logic [7:4]  CHIP_SEL_OUT,
  input  wire logic        ROW_STROBE_OUT,
  input  wire logic [1:0]  PARITY_O,
  input  wire logic [1:0]  PARITY_OE,
  input  wire logic [3:0]  TIMER_CC_O,
  input  wire logic [3:0]  TIMER_CC_OE,
  output logic      [3:0]  EXT_IRQ_IN,
  output logic      [1:0]  XFER_REQ_IN,
  output logic      [1:0]  TIMER_CLK_IN,
  output logic      [3:0]  TIMER_CC_IN,
  output logic      [1:0]  PARITY_IN,
  output logic             CONV_TRIGGER_IN,
  output logic             BUS_REQ_IN,
  output logic             WAIT_IN
);

  pafs_pkg::pafs_regs_t r;
  pafs_pkg::pafs_regs_t n;
  logic [31:0]          fn;
  logic                 req;

  // merge written byte lanes and force reserved bits to one
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
                                        input logic [1:0] be, input logic [15:0] rsv);
    logic [15:0] v;
    v = old;
    if (be[0]) begin
      v[7:0] = wd[7:0];
    end
    if (be[1]) begin
      v[15:8] = wd[15:8];
    end
    merge = v | rsv;
  endfunction

  // read multiplexer, upper half and unmapped words read zero
  function automatic logic [31:0] rd_mux(input logic [3:0] a, input logic [15:0] h,
                                         input logic [15:0] l);
    rd_mux = 32'h0000_0000;
    if (a == `PAFS_OFF_HIGH) begin
      rd_mux = {16'h0000, h | `PAFS_RSV_HIGH};
    end else if (a == `PAFS_OFF_LOW) begin
      rd_mux = {16'h0000, l | `PAFS_RSV_LOW};
    end
  endfunction

  // per-pin function codes
  pafs_fn_dec u_dec (
    .hi (r.hi),
    .lo (r.lo),
    .fn (fn)
  );

  assign req = AVM_READ | AVM_WRITE;

  // next state: bus slave and pin multiplexer
  always_comb begin
    n = r;
    // bus handshake: wait one cycle, then answer
    case (r.st)
      pafs_pkg::PAFS_IDLE: begin
        if (req) begin
          n.st    = pafs_pkg::PAFS_ACK;
          n.wreq  = 1'b0;
          n.rdata = rd_mux(AVM_ADDRESS, r.hi, r.lo);
        end
      end
      pafs_pkg::PAFS_ACK: begin
        n.st   = pafs_pkg::PAFS_IDLE;
        n.wreq = 1'b1;
        if (AVM_WRITE && AVM_ADDRESS == `PAFS_OFF_HIGH) begin
          n.hi = merge(r.hi, AVM_WRITEDATA[15:0], AVM_BYTEENABLE[1:0],
                       `PAFS_RSV_HIGH);
        end
        if (AVM_WRITE && AVM_ADDRESS == `PAFS_OFF_LOW) begin
          n.lo = merge(r.lo, AVM_WRITEDATA[15:0], AVM_BYTEENABLE[1:0],
                       `PAFS_RSV_LOW);
        end
      end
      default: begin
        n.st   = pafs_pkg::PAFS_IDLE;
        n.wreq = 1'b1;
      end
    endcase

    // pins default to the port: port data, port direction
    n.pin_out = PORT_DOUT;
    n.pin_oe  = PORT_DIR;
    n.port_in = PIN_IN;
    n.irq     = 4'h0;
    n.xreq    = 2'h0;
    n.tclk    = 2'h0;
    n.tcc     = 4'h0;
    n.par     = 2'h0;
    n.trg     = 1'b0;
    n.bus_req_in    = 1'b0;
    n.wt      = 1'b0;

    // pin 15
    case (fn[31:30])
      `PAFS_FN_ALT1: begin n.irq[3] = PIN_IN[15]; n.pin_oe[15] = 1'b0; end
      `PAFS_FN_ALT3: begin n.xreq[1] = PIN_IN[15]; n.pin_oe[15] = 1'b0; end
      default: ;
    endcase
    // pin 14
    case (fn[29:28])
      `PAFS_FN_ALT1: begin n.irq[2] = PIN_IN[14]; n.pin_oe[14] = 1'b0; end
      `PAFS_FN_ALT3: begin n.pin_out[14] = XFER_ACK_OUT[1]; n.pin_oe[14] = 1'b1; end
      default: ;
    endcase
    // pin 13
    case (fn[27:26])
      `PAFS_FN_ALT1: begin n.irq[1] = PIN_IN[13]; n.pin_oe[13] = 1'b0; end
      `PAFS_FN_ALT2: begin n.tclk[1] = PIN_IN[13]; n.pin_oe[13] = 1'b0; end
      `PAFS_FN_ALT3: begin n.xreq[0] = PIN_IN[13]; n.pin_oe[13] = 1'b0; end
      default: ;
    endcase
    // pin 12
    case (fn[25:24])
      `PAFS_FN_ALT1: begin n.irq[0] = PIN_IN[12]; n.pin_oe[12] = 1'b0; end
      `PAFS_FN_ALT2: begin n.tclk[0] = PIN_IN[12]; n.pin_oe[12] = 1'b0; end
      `PAFS_FN_ALT3: begin n.pin_out[12] = XFER_ACK_OUT[0]; n.pin_oe[12] = 1'b1; end
      default: ;
    endcase
    // pin 11, two-way alternates
    case (fn[23:22])
      `PAFS_FN_ALT1: begin
        n.par[1]      = PIN_IN[11];
        n.pin_out[11] = PARITY_O[1];
        n.pin_oe[11]  = PARITY_OE[1];
      end
      `PAFS_FN_ALT2: begin
        n.tcc[3]      = PIN_IN[11];
        n.pin_out[11] = TIMER_CC_O[3];
        n.pin_oe[11]  = TIMER_CC_OE[3];
      end
      default: ;
    endcase
    // pin 10, two-way alternates
    case (fn[21:20])
      `PAFS_FN_ALT1: begin
        n.par[0]      = PIN_IN[10];
        n.pin_out[10] = PARITY_O[0];
        n.pin_oe[10]  = PARITY_OE[0];
      end
      `PAFS_FN_ALT2: begin
        n.tcc[2]      = PIN_IN[10];
        n.pin_out[10] = TIMER_CC_O[2];
        n.pin_oe[10]  = TIMER_CC_OE[2];
      end
      default: ;
    endcase
    // pin 9
    case (fn[19:18])
      `PAFS_FN_ALT1: begin n.pin_out[9] = ADDR_HOLD_OUT; n.pin_oe[9] = 1'b1; end
      `PAFS_FN_ALT2: begin n.trg = PIN_IN[9]; n.pin_oe[9] = 1'b0; end
      `PAFS_FN_ALT3: begin n.pin_out[9] = IRQ_REQUEST_OUT; n.pin_oe[9] = 1'b1; end
      default: ;
    endcase
    // pins 8..4, single-bit selects
    if (fn[17:16] == `PAFS_FN_ALT1) begin
      n.bus_req_in      = PIN_IN[8];
      n.pin_oe[8] = 1'b0;
    end
    if (fn[15:14] == `PAFS_FN_ALT1) begin
      n.pin_out[7] = BUS_ACK_OUT;
      n.pin_oe[7]  = 1'b1;
    end
    if (fn[13:12] == `PAFS_FN_ALT1) begin
      n.pin_out[6] = READ_STROBE_OUT;
      n.pin_oe[6]  = 1'b1;
    end
    if (fn[11:10] == `PAFS_FN_ALT1) begin
      n.pin_out[5] = UPPER_WRITE_STROBE;
      n.pin_oe[5]  = 1'b1;
    end
    if (fn[9:8] == `PAFS_FN_ALT1) begin
      n.pin_out[4] = LOWER_WRITE_STROBE;
      n.pin_oe[4]  = 1'b1;
    end
    // pin 3
    case (fn[7:6])
      `PAFS_FN_ALT1: begin n.pin_out[3] = CHIP_SEL_OUT[7]; n.pin_oe[3] = 1'b1; end
      `PAFS_FN_ALT2: begin n.wt = PIN_IN[3]; n.pin_oe[3] = 1'b0; end
      default: ;
    endcase
    // pin 2
    case (fn[5:4])
      `PAFS_FN_ALT1: begin n.pin_out[2] = CHIP_SEL_OUT[6]; n.pin_oe[2] = 1'b1; end
      `PAFS_FN_ALT2: begin
        n.tcc[1]     = PIN_IN[2];
        n.pin_out[2] = TIMER_CC_O[1];
        n.pin_oe[2]  = TIMER_CC_OE[1];
      end
      default: ;
    endcase
    // pin 1
    case (fn[3:2])
      `PAFS_FN_ALT1: begin n.pin_out[1] = CHIP_SEL_OUT[5]; n.pin_oe[1] = 1'b1; end
      `PAFS_FN_ALT2: begin n.pin_out[1] = ROW_STROBE_OUT; n.pin_oe[1] = 1'b1; end
      default: ;
    endcase
    // pin 0
    case (fn[1:0])
      `PAFS_FN_ALT1: begin n.pin_out[0] = CHIP_SEL_OUT[4]; n.pin_oe[0] = 1'b1; end
      `PAFS_FN_ALT2: begin
        n.tcc[0]     = PIN_IN[0];
        n.pin_out[0] = TIMER_CC_O[0];
        n.pin_oe[0]  = TIMER_CC_OE[0];
      end
      default: ;
    endcase
  end

  // state register; only the power-on reset reloads the selects
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      r         <= '0;
      r.st      <= pafs_pkg::PAFS_IDLE;
      r.wreq    <= 1'b1;
      r.hi      <= `PAFS_RST_HIGH;
      r.lo      <= `PAFS_RST_LOW;
    end else begin
      r <= n;
    end
  end

  // outputs straight from the state register
  assign AVM_READDATA    = r.rdata;
  assign AVM_WAITREQUEST = r.wreq;
  assign PIN_OUT         = r.pin_out;
  assign PIN_OE          = r.pin_oe;
  assign PORT_PIN_IN     = r.port_in;
  assign EXT_IRQ_IN      = r.irq;
  assign XFER_REQ_IN     = r.xreq;
  assign TIMER_CLK_IN    = r.tclk;
  assign TIMER_CC_IN     = r.tcc;
  assign PARITY_IN       = r.par;
  assign CONV_TRIGGER_IN = r.trg;
  assign BUS_REQ_IN      = r.bus_req_in;
  assign WAIT_IN         = r.wt;

  // checks
  a_reset_load:
    assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      $rose(RST_B) |-> (r.hi == `PAFS_RST_HIGH && r.lo == `PAFS_RST_LOW))
    else $error("select registers not at reset values");

  a_sel_hold:
    assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      !(AVM_WRITE && !AVM_WAITREQUEST) |=> $stable(r.hi) && $stable(r.lo))
    else $error("select register changed without a write");

  a_write_hi_takes:
    assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      (AVM_WRITE && !AVM_WAITREQUEST && AVM_ADDRESS == `PAFS_OFF_HIGH
       && AVM_BYTEENABLE[1:0] == 2'h3)
      |=> r.hi == ($past(AVM_WRITEDATA[15:0]) | `PAFS_RSV_HIGH))
    else $error("high select write lost");

  a_hi_rsv_one:
    assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      (!AVM_WAITREQUEST && AVM_READ && AVM_ADDRESS == `PAFS_OFF_HIGH)
      |-> AVM_READDATA[1])
    else $error("high reserved bit read as zero");

  a_lo_rsv_one:
    assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      (!AVM_WAITREQUEST && AVM_READ && AVM_ADDRESS == `PAFS_OFF_LOW)
      |-> (AVM_READDATA[15:0] & `PAFS_RSV_LOW) == `PAFS_RSV_LOW)
    else $error("low reserved bits read as zero");

  a_bus_answer:
    assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      (req && AVM_WAITREQUEST && r.st == pafs_pkg::PAFS_IDLE) |=> !AVM_WAITREQUEST ##1
      AVM_WAITREQUEST)
    else $error("bus answer not in one cycle");

  a_pin15_xreq:
    assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      r.hi[`PAFS_HI_PIN15] == `PAFS_FN_ALT3 |=> XFER_REQ_IN[1] == $past(PIN_IN[15])
      && !PIN_OE[15])
    else $error("pin 15 transfer request not routed");

  a_pin15_rsv:
    assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      r.hi[`PAFS_HI_PIN15] == `PAFS_FN_ALT2 |=> PIN_OE[15] == $past(PORT_DIR[15])
      && EXT_IRQ_IN[3] == 1'b0 && XFER_REQ_IN[1] == 1'b0)
    else $error("reserved code on pin 15 not port");

  a_pin14_ack:
    assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      r.hi[`PAFS_HI_PIN14] == `PAFS_FN_ALT3 |=> PIN_OE[14]
      && PIN_OUT[14] == $past(XFER_ACK_OUT[1]))
    else $error("pin 14 acknowledge not driven");

  a_pin9_irq_request_out:
    assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      r.hi[`PAFS_HI_PIN9] == `PAFS_FN_ALT3 |=> PIN_OE[9]
      && PIN_OUT[9] == $past(IRQ_REQUEST_OUT))
    else $error("pin 9 interrupt request not driven");

  a_pin7_port:
    assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      !r.lo[`PAFS_LO_PIN7] |=> PIN_OE[7] == $past(PORT_DIR[7])
      && PIN_OUT[7] == $past(PORT_DOUT[7]))
    else $error("pin 7 not in port function");

endmodule

//--- verif/test_pafs_top.sv
// self-checking bench for the port a function select block
`timescale 1ns/100ps
`include "pafs_defines.svh"

module test_pafs_top;
  logic        SYS_CLK, RST_B, AVM_READ, AVM_WRITE, AVM_WAITREQUEST;
  logic [3:0]  AVM_ADDRESS, AVM_BYTEENABLE;
  logic [31:0] AVM_WRITEDATA, AVM_READDATA;
  logic [15:0] PIN_IN, PIN_OUT, PIN_OE, PORT_DOUT, PORT_DIR, PORT_PIN_IN;
  logic [1:0]  XFER_ACK_OUT, PARITY_O, PARITY_OE, XFER_REQ_IN, TIMER_CLK_IN, PARITY_IN;
  logic [3:0]  TIMER_CC_O, TIMER_CC_OE, EXT_IRQ_IN, TIMER_CC_IN;
  logic [7:4]  CHIP_SEL_OUT;
  logic        ADDR_HOLD_OUT, IRQ_REQUEST_OUT, BUS_ACK_OUT, READ_STROBE_OUT;
  logic        UPPER_WRITE_STROBE, LOWER_WRITE_STROBE, ROW_STROBE_OUT;
  logic        CONV_TRIGGER_IN, BUS_REQ_IN, WAIT_IN, pin_vld;
  int          errors, checked;
  logic [15:0] seed, hi_m, lo_m;
  logic [31:0] rd_q[$];
  logic [64:0] pin_q[$];

  pafs_top u_dut (
    .SYS_CLK(SYS_CLK), .RST_B(RST_B), .AVM_ADDRESS(AVM_ADDRESS), .AVM_READ(AVM_READ),
    .AVM_WRITE(AVM_WRITE), .AVM_WRITEDATA(AVM_WRITEDATA), .AVM_BYTEENABLE(AVM_BYTEENABLE),
    .AVM_READDATA(AVM_READDATA), .AVM_WAITREQUEST(AVM_WAITREQUEST), .PIN_IN(PIN_IN),
    .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .PORT_DOUT(PORT_DOUT), .PORT_DIR(PORT_DIR),
    .PORT_PIN_IN(PORT_PIN_IN), .XFER_ACK_OUT(XFER_ACK_OUT), .ADDR_HOLD_OUT(ADDR_HOLD_OUT),
    .IRQ_REQUEST_OUT(IRQ_REQUEST_OUT), .BUS_ACK_OUT(BUS_ACK_OUT),
    .READ_STROBE_OUT(READ_STROBE_OUT), .UPPER_WRITE_STROBE(UPPER_WRITE_STROBE),
    .LOWER_WRITE_STROBE(LOWER_WRITE_STROBE), .CHIP_SEL_OUT(CHIP_SEL_OUT),
    .ROW_STROBE_OUT(ROW_STROBE_OUT), .PARITY_O(PARITY_O), .PARITY_OE(PARITY_OE),
    .TIMER_CC_O(TIMER_CC_O), .TIMER_CC_OE(TIMER_CC_OE), .EXT_IRQ_IN(EXT_IRQ_IN),
    .XFER_REQ_IN(XFER_REQ_IN), .TIMER_CLK_IN(TIMER_CLK_IN), .TIMER_CC_IN(TIMER_CC_IN),
    .PARITY_IN(PARITY_IN), .CONV_TRIGGER_IN(CONV_TRIGGER_IN), .BUS_REQ_IN(BUS_REQ_IN),
    .WAIT_IN(WAIT_IN)
  );

  // 200 mhz system clock
  initial begin
    SYS_CLK = 1'b0;
    forever #2.5 SYS_CLK = ~SYS_CLK;
  end

  // next value of the pseudo-random sequence
  function automatic logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction

  // expected pad and peripheral state for the given selects and current inputs
  function automatic logic [64:0] model(input logic [15:0] h, input logic [15:0] l);
    logic [1:0]  c15, c14, c13, c12, c11, c10, c9, c3, c2, c1, c0;
    logic [15:0] sel, aoe, ao, oe;
    {c15, c14, c13, c12, c11, c10, c9} = h[15:2];
    {c3, c2, c1, c0} = l[7:0];
    sel = {c15[0], c14[0], c13 != 2'h0, c12 != 2'h0, c11 != 2'h0 && c11 != 2'h3,
           c10 != 2'h0 && c10 != 2'h3, c9 != 2'h0, h[0], l[14], l[12], l[10], l[8],
           c3 != 2'h0 && c3 != 2'h3, c2 != 2'h0 && c2 != 2'h3, c1 != 2'h0 && c1 != 2'h3,
           c0 != 2'h0 && c0 != 2'h3};
    aoe = {1'b0, c14 == 2'h3, 1'b0, c12 == 2'h3, c11 == 2'h1 ? PARITY_OE[1] : TIMER_CC_OE[3],
           c10 == 2'h1 ? PARITY_OE[0] : TIMER_CC_OE[2], c9[0], 1'b0, 4'hf, c3 == 2'h1,
           c2 == 2'h1 || TIMER_CC_OE[1], 1'b1, c0 == 2'h1 || TIMER_CC_OE[0]};
    ao = {1'b0, XFER_ACK_OUT[1], 1'b0, XFER_ACK_OUT[0],
          c11 == 2'h1 ? PARITY_O[1] : TIMER_CC_O[3], c10 == 2'h1 ? PARITY_O[0] : TIMER_CC_O[2],
          c9 == 2'h1 ? ADDR_HOLD_OUT : IRQ_REQUEST_OUT, 1'b0, BUS_ACK_OUT, READ_STROBE_OUT,
          UPPER_WRITE_STROBE, LOWER_WRITE_STROBE, CHIP_SEL_OUT[7],
          c2 == 2'h1 ? CHIP_SEL_OUT[6] : TIMER_CC_O[1],
          c1 == 2'h1 ? CHIP_SEL_OUT[5] : ROW_STROBE_OUT,
          c0 == 2'h1 ? CHIP_SEL_OUT[4] : TIMER_CC_O[0]};
    oe = (PORT_DIR & ~sel) | (aoe & sel);
    return {PIN_IN, oe, ((PORT_DOUT & ~sel) | (ao & sel)) & oe,
            PIN_IN[15] && c15 == 2'h1, PIN_IN[14] && c14 == 2'h1, PIN_IN[13] && c13 == 2'h1,
            PIN_IN[12] && c12 == 2'h1, PIN_IN[15] && c15 == 2'h3, PIN_IN[13] && c13 == 2'h3,
            PIN_IN[13] && c13 == 2'h2, PIN_IN[12] && c12 == 2'h2,
            PIN_IN[11] && c11 == 2'h2, PIN_IN[10] && c10 == 2'h2, PIN_IN[2] && c2 == 2'h2,
            PIN_IN[0] && c0 == 2'h2, PIN_IN[11] && c11 == 2'h1, PIN_IN[10] && c10 == 2'h1,
            PIN_IN[9] && c9 == 2'h2, PIN_IN[8] && h[0], PIN_IN[3] && c3 == 2'h2};
  endfunction

  // compare one result, report and count a mismatch
  task automatic check(input logic [64:0] got, input logic [64:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // one bus access held until waitrequest is sampled low; the watchdog bounds the wait
  task automatic bus(input logic wr, input logic [3:0] a, input logic [15:0] d,
                     input logic [3:0] be);
    @(posedge SYS_CLK);
    AVM_ADDRESS    <= a;
    AVM_WRITE      <= wr;
    AVM_READ       <= ~wr;
    AVM_WRITEDATA  <= {rnd(), d};
    AVM_BYTEENABLE <= be;
    do begin
      @(posedge SYS_CLK);
    end while (AVM_WAITREQUEST !== 1'b0);
    AVM_WRITE <= 1'b0;
    AVM_READ  <= 1'b0;
  endtask

  // register write; the shadow copy keeps lane merge and forced spare bits
  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d, input logic [3:0] be);
    logic [15:0] w;
    w = d | (a == `PAFS_OFF_HIGH ? `PAFS_RSV_HIGH :
             a == `PAFS_OFF_LOW ? `PAFS_RSV_LOW : 16'h0000);
    bus(1'b1, a, w, be);
    if (a == `PAFS_OFF_HIGH)
      hi_m = {be[1] ? d[15:8] : hi_m[15:8], be[0] ? d[7:0] : hi_m[7:0]} | `PAFS_RSV_HIGH;
    if (a == `PAFS_OFF_LOW)
      lo_m = {be[1] ? d[15:8] : lo_m[15:8], be[0] ? d[7:0] : lo_m[7:0]} | `PAFS_RSV_LOW;
  endtask

  // register read; expected word noted before the request
  task automatic reg_rd(input logic [3:0] a);
    rd_q.push_back(a == `PAFS_OFF_HIGH ? {16'h0000, hi_m} :
                   a == `PAFS_OFF_LOW ? {16'h0000, lo_m} : 32'h0);
    bus(1'b0, a, 16'h0000, 4'hf);
  endtask

  // random pads and peripheral drives, checked one cycle after sampling
  task automatic pin_case();
    logic [31:0] r;
    r = {rnd(), rnd()};
    @(posedge SYS_CLK);
    PIN_IN    <= rnd();
    PORT_DOUT <= rnd();
    PORT_DIR  <= rnd();
    {XFER_ACK_OUT, ADDR_HOLD_OUT, IRQ_REQUEST_OUT, BUS_ACK_OUT, READ_STROBE_OUT,
     UPPER_WRITE_STROBE, LOWER_WRITE_STROBE, CHIP_SEL_OUT, ROW_STROBE_OUT, PARITY_O,
     PARITY_OE, TIMER_CC_O, TIMER_CC_OE} <= r[24:0];
    @(posedge SYS_CLK);
    pin_q.push_back(model(hi_m, lo_m));
    pin_vld <= 1'b1;
    @(posedge SYS_CLK);
    pin_vld <= 1'b0;
  endtask

  // watcher: takes the oldest note whenever a result shows
  always @(posedge SYS_CLK) begin
    if (AVM_READ === 1'b1 && AVM_WAITREQUEST === 1'b0) begin
      if (rd_q.size() > 0)
        check({33'h0, AVM_READDATA}, {33'h0, rd_q.pop_front()}, "read data");
      else begin
        errors++;
        $display("BAD %0t: read answer with no note", $time);
      end
    end
    if (pin_vld === 1'b1 && pin_q.size() > 0)
      check({PORT_PIN_IN, PIN_OE, PIN_OUT & PIN_OE, EXT_IRQ_IN, XFER_REQ_IN, TIMER_CLK_IN,
             TIMER_CC_IN, PARITY_IN, CONV_TRIGGER_IN, BUS_REQ_IN, WAIT_IN},
            pin_q.pop_front(), "pin state");
    else if (pin_vld === 1'b1) begin
      errors++;
      $display("BAD %0t: pin result with no note", $time);
    end
  end

  // counts, verdict and end of run
  task automatic give_verdict();
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // watchdog: the run needs well under 2000 cycles
  initial begin
    #50000;
    errors++;
    $display("BAD %0t: run did not finish", $time);
    give_verdict();
  end

  // main sequence
  initial begin
    logic [15:0] r;
    RST_B = 1'b0;
    {AVM_ADDRESS, AVM_READ, AVM_WRITE, AVM_WRITEDATA, AVM_BYTEENABLE} = '0;
    {PIN_IN, PORT_DOUT, PORT_DIR, XFER_ACK_OUT, PARITY_O, PARITY_OE, TIMER_CC_O} = '0;
    {TIMER_CC_OE, CHIP_SEL_OUT, ADDR_HOLD_OUT, IRQ_REQUEST_OUT, BUS_ACK_OUT} = '0;
    {READ_STROBE_OUT, UPPER_WRITE_STROBE, LOWER_WRITE_STROBE, ROW_STROBE_OUT} = '0;
    {errors, checked, pin_vld} = '0;
    seed = 16'h28f8;
    hi_m = `PAFS_RST_HIGH;
    lo_m = `PAFS_RST_LOW;
    repeat (12) @(posedge SYS_CLK);
    RST_B <= 1'b1;
    // reset values and reset pin choices
    reg_rd(`PAFS_OFF_HIGH);
    reg_rd(`PAFS_OFF_LOW);
    repeat (3) pin_case();
    // zero fields, spare bits written as one: pins fall back to port
    reg_wr(`PAFS_OFF_HIGH, 16'h0000, 4'hf);
    reg_wr(`PAFS_OFF_LOW, 16'h0000, 4'hf);
    reg_rd(`PAFS_OFF_HIGH);
    reg_rd(`PAFS_OFF_LOW);
    repeat (2) pin_case();
    // every code in every field, reserved codes included
    for (int k = 0; k < 4; k++) begin
      reg_wr(`PAFS_OFF_HIGH, {{7{k[1:0]}}, 1'b1, k[0]}, 4'h3);
      reg_wr(`PAFS_OFF_LOW, {{4{1'b1, k[0]}}, {4{k[1:0]}}}, 4'h3);
      reg_rd(`PAFS_OFF_HIGH);
      reg_rd(`PAFS_OFF_LOW);
      repeat (4) pin_case();
    end
    // random selects, byte lanes and spare addresses
    for (int i = 0; i < 24; i++) begin
      r = rnd();
      reg_wr({r[1:0], 2'h0}, rnd(), r[7:4]);
      reg_rd({r[3:2], 2'h0});
      pin_case();
    end
    // power-on reset again in mid-run
    @(posedge SYS_CLK);
    RST_B <= 1'b0;
    repeat (3) @(posedge SYS_CLK);
    RST_B <= 1'b1;
    hi_m = `PAFS_RST_HIGH;
    lo_m = `PAFS_RST_LOW;
    reg_rd(`PAFS_OFF_HIGH);
    reg_rd(`PAFS_OFF_LOW);
    pin_case();
    repeat (2) @(posedge SYS_CLK);
    give_verdict();
  end
endmodule
